// ---- sim/flash_security_serial_boot_gate_bench.sv ----
`timescale 1ns/1ns
module flash_security_serial_boot_gate_bench;
    import fsg_pkg::*;
    logic ref_clk = 0, nrst = 0, lo = 0, hi = 0, ext = 0, tr = 0, fr = 0, oscDrv = 0;
    logic commStart = 0, txLine = 0, pullReq = 0, dpDrv = 0, dmDrv = 0, dpTx = 0;
    logic dmTx = 0, txEn = 0, cmdValid = 0, cmdIsErase = 0, rdValid = 0, dbgValid = 0;
    logic progWe = 0, chipErase = 0;
    logic [5:0] boardOsc = 6'h04;
    logic [31:0] rdData = 32'h0;
    logic [15:0] progData = 16'h0;
    logic [3:0] ackDelay = 4'h0;
    logic oscOut, oscOe, rxLine, pullN, dpOut, dpOe, dmOut, dmOe, dpRx, dmRx, secRdReq;
    logic secRdAck, cmdGo, cmdRefused, rdOutValid, dbgGrant, dbgBlocked, bootDone;
    logic armed, writer, usb, async, commAct;
    logic [31:0] secRdAddr, rdOut;
    logic [15:0] secRdData;
    logic [5:0] oscMhz;
    logic [16:0] bps;
    logic [5:0] oscTab [5] = '{6'h04, 6'h08, 6'h10, 6'h18, 6'h30};
    logic [16:0] bpsTab [5] = '{17'h02580, 17'h04B00, 17'h09600, 17'h0E100, 17'h1C200};
    int fails = 0, n_compared = 0, i;
    wire oscPin = oscOe ? oscOut : oscDrv;
    wire dpPin = dpOe ? dpOut : dpDrv;
    wire dmPin = dmOe ? dmOut : dmDrv;

    always #25 ref_clk = ~ref_clk;

    fsg_gate u_fsg_gate (.ref_clk(ref_clk), .nrst(nrst), .bootStrapLowBit(lo),
        .bootStrapHighBit(hi), .extResetOrPowerUp(ext), .transportSelectPin(tr),
        .framingSelectRxdPin(fr), .oscSelectTxdPinIn(oscPin), .oscSelectTxdPinOut(oscOut),
        .oscSelectTxdPinOe(oscOe), .boardOscMhz(boardOsc), .commStart(commStart),
        .serialTransmitLine(txLine), .serialReceiveLine(rxLine), .usbPullupReq(pullReq),
        .usbPullupEnableN(pullN), .usbPositiveLineIn(dpPin), .usbPositiveLineOut(dpOut),
        .usbPositiveLineOe(dpOe), .usbNegativeLineIn(dmPin), .usbNegativeLineOut(dmOut),
        .usbNegativeLineOe(dmOe), .usbDpTx(dpTx), .usbDmTx(dmTx), .usbTxEn(txEn),
        .usbDpRx(dpRx), .usbDmRx(dmRx), .secRdReq(secRdReq), .secRdAddr(secRdAddr),
        .secRdAck(secRdAck), .secRdData(secRdData), .cmdValid(cmdValid),
        .cmdIsErase(cmdIsErase), .rdValid(rdValid), .rdData(rdData), .dbgValid(dbgValid),
        .cmdGo(cmdGo), .cmdRefused(cmdRefused), .rdOut(rdOut), .rdOutValid(rdOutValid),
        .dbgGrant(dbgGrant), .dbgBlocked(dbgBlocked), .bootDone(bootDone),
        .securityArmed(armed), .serialWriteMode(writer), .usbTransport(usb),
        .asyncFraming(async), .commActive(commAct), .oscFreqMhz(oscMhz),
        .bitRateBps(bps));

    fsg_flash_model u_fsg_flash_model (.ref_clk(ref_clk), .nrst(nrst),
        .secRdReq(secRdReq), .secRdAddr(secRdAddr), .progWe(progWe),
        .progData(progData), .chipErase(chipErase), .ackDelay(ackDelay),
        .secRdAck(secRdAck), .secRdData(secRdData));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task conclude;
        $display("Compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task boot(input logic l, h, e, t, f, o, input logic [3:0] d);
        int k;
        @(posedge ref_clk);
        nrst <= 0; lo <= l; hi <= h; ext <= e; tr <= t; fr <= f; oscDrv <= o; ackDelay <= d;
        repeat (8) @(posedge ref_clk);
        nrst <= 1;
        for (k = 0; k < 40 && bootDone !== 1'b1; k++) @(posedge ref_clk);
        commStart <= 1;
        @(posedge ref_clk);
        commStart <= 0;
        repeat (4) @(posedge ref_clk);
        #1;
        chk("bootDone", 1, bootDone);
        chk("commAct", 1, commAct);
    endtask

    task req(input int kind, input logic er, input logic [31:0] d);
        @(posedge ref_clk);
        cmdValid <= (kind == 0); cmdIsErase <= er; rdValid <= (kind == 1); rdData <= d;
        dbgValid <= (kind == 2);
        @(posedge ref_clk);
        cmdValid <= 0; rdValid <= 0; dbgValid <= 0;
        #1;
    endtask

    task prog(input logic er, input logic [15:0] v);
        @(posedge ref_clk);
        progWe <= !er; chipErase <= er; progData <= v;
        @(posedge ref_clk);
        progWe <= 0; chipErase <= 0;
        #1;
    endtask

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        prog(1, 16'h0000);
        boot(0, 0, 1, 0, 1, 0, 0);
        chk("armed", 0, armed);
        prog(0, 16'h0002);
        boot(0, 0, 1, 0, 1, 0, 3);
        chk("armed", 0, armed);
        prog(0, 16'h0001);
        chk("armed", 0, armed);
        boot(0, 0, 1, 0, 1, 0, 7);
        chk("armed", 1, armed);
        req(0, 0, 0); chk("cmdGo", 1, cmdGo);
        req(1, 0, 32'hA5C3_0F12); chk("rdOut", 32'hA5C3_0F12, rdOut);
        req(2, 0, 0); chk("dbgBlocked", 1, dbgBlocked);
        boot(1, 0, 1, 0, 1, 0, 0);
        chk("writer", 1, writer);
        chk("usb", 0, usb);
        req(0, 0, 0); chk("cmdRefused", 1, cmdRefused);
        req(1, 0, 32'h1234_5678); chk("rdOut", 32'hFFFF_FFFF, rdOut);
        req(2, 0, 0); chk("dbgGrant", 0, dbgGrant);
        req(0, 1, 0); chk("cmdGo", 1, cmdGo);
        prog(1, 16'h0000);
        chk("armed", 1, armed);
        boot(1, 0, 1, 0, 1, 0, 2);
        chk("armed", 0, armed);
        req(2, 0, 0); chk("dbgGrant", 1, dbgGrant);
        boot(1, 0, 0, 0, 1, 0, 0);
        chk("writer", 0, writer);
        for (i = 0; i < 5; i++) begin
            @(posedge ref_clk);
            boardOsc <= oscTab[i];
            boot(1, 0, 1, 0, 1, 0, 0);
            chk("bps", bpsTab[i], bps);
            @(posedge ref_clk);
            fr <= i[0]; txLine <= !i[0];
            repeat (4) @(posedge ref_clk);
            #1;
            chk("async", 1, async);
            chk("rxLine", i[0], rxLine);
            chk("txOe", 1, oscOe);
            chk("txOut", !i[0], oscOut);
        end
        boot(1, 0, 1, 0, 0, 0, 0);
        chk("async", 0, async);
        for (i = 0; i < 2; i++) begin
            boot(1, 0, 1, 1, 1, i[0], 0);
            chk("usb", 1, usb);
            chk("oscMhz", i[0] ? 6'h30 : 6'h04, oscMhz);
            @(posedge ref_clk);
            pullReq <= 1; txEn <= 1; dpTx <= i[0]; dmTx <= !i[0];
            repeat (4) @(posedge ref_clk);
            #1;
            chk("pullN", 0, pullN);
            chk("dpOe", 1, dpOe);
            chk("dpOut", i[0], dpOut);
            chk("dmOut", !i[0], dmOut);
            chk("dmOe", 1, dmOe);
            chk("txOe", 0, oscOe);
            @(posedge ref_clk);
            pullReq <= 0; txEn <= 0; dpDrv <= !i[0]; dmDrv <= i[0];
            repeat (5) @(posedge ref_clk);
            #1;
            chk("pullN", 1, pullN);
            chk("dpRx", !i[0], dpRx);
            chk("dmRx", i[0], dmRx);
        end
        conclude();
    end

    initial begin
        #(6000 * 50);
        fails++;
        conclude();
    end
endmodule // flash_security_serial_boot_gate_bench

// ---- sim/fsg_flash_model.sv ----
`timescale 1ns/1ns
`include "fsg_params.svh"
module fsg_flash_model (
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    input  wire logic        secRdReq,
    input  wire logic [31:0] secRdAddr,
    input  wire logic        progWe,
    input  wire logic [15:0] progData,
    input  wire logic        chipErase,
    input  wire logic [3:0]  ackDelay,
    output logic             secRdAck,
    output logic [15:0]      secRdData
);
    // ----------------------------------------
    // Nonvolatile word and read answer
    // ----------------------------------------
    logic [15:0] codeWord;
    logic        pending;
    logic        hitAddr;
    logic [3:0]  cnt;

    // Word kept across resets, erase sets all ones
    always_ff @(posedge ref_clk) begin
        if (chipErase) begin
            codeWord <= 16'hFFFF;
        end else if (progWe) begin
            codeWord <= progData;
        end
    end

    // Halfword answer at the security address
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pending   <= 1'b0;
            hitAddr   <= 1'b0;
            cnt       <= 4'h0;
            secRdAck  <= 1'b0;
            secRdData <= 16'h0000;
        end else if (secRdReq) begin
            pending   <= 1'b1;
            hitAddr   <= (secRdAddr == `FSG_SEC_ADDR);
            cnt       <= ackDelay;
            secRdAck  <= 1'b0;
            secRdData <= ~secRdData;
        end else if (pending && cnt == 4'h0) begin
            pending   <= 1'b0;
            secRdAck  <= 1'b1;
            secRdData <= hitAddr ? codeWord : ~codeWord;
        end else begin
            cnt       <= (cnt == 4'h0) ? 4'h0 : cnt - 4'h1;
            secRdAck  <= 1'b0;
            secRdData <= ~secRdData;
        end
    end
endmodule // fsg_flash_model

// ---- sim/fsg_gate_properties.sv ----
`timescale 1ns/1ns
module fsg_gate_properties (
    input wire logic        ref_clk,
    input wire logic        nrst,
    input wire logic        secRdReq,
    input wire logic [31:0] secRdAddr,
    input wire logic        secRdAck,
    input wire logic [15:0] secRdData,
    input wire logic        cmdValid,
    input wire logic        cmdIsErase,
    input wire logic        rdValid,
    input wire logic [31:0] rdData,
    input wire logic        dbgValid,
    input wire logic        cmdGo,
    input wire logic        cmdRefused,
    input wire logic [31:0] rdOut,
    input wire logic        rdOutValid,
    input wire logic        dbgGrant,
    input wire logic        dbgBlocked,
    input wire logic        bootDone,
    input wire logic        securityArmed,
    input wire logic        serialWriteMode,
    input wire logic        usbTransport
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    property p_sec_addr;
        secRdReq |-> secRdAddr == 32'h0010_0000;
    endproperty
    a_sec_addr: assert property (p_sec_addr) else $error("bad code address");

    property p_boot_read;
        secRdAck && !bootDone |=> bootDone && securityArmed == ($past(secRdData) == 16'h0001);
    endproperty
    a_boot_read: assert property (p_boot_read) else $error("armed state wrong");

    property p_hold;
        bootDone |=> bootDone && $stable(securityArmed) && $stable(serialWriteMode)
            && $stable(usbTransport);
    endproperty
    a_hold: assert property (p_hold) else $error("latched state moved");

    property p_dbg;
        dbgValid && securityArmed |=> dbgBlocked && !dbgGrant;
    endproperty
    a_dbg: assert property (p_dbg) else $error("debug access let through");

    property p_user_cmd;
        cmdValid && bootDone && !serialWriteMode |=> cmdGo && !cmdRefused;
    endproperty
    a_user_cmd: assert property (p_user_cmd) else $error("user command refused");

    property p_user_rd;
        rdValid && bootDone && !serialWriteMode |=> rdOutValid && rdOut == $past(rdData);
    endproperty
    a_user_rd: assert property (p_user_rd) else $error("user read data wrong");

    property p_wr_cmd;
        cmdValid && securityArmed && serialWriteMode
            |=> cmdGo == $past(cmdIsErase) && cmdRefused == !$past(cmdIsErase);
    endproperty
    a_wr_cmd: assert property (p_wr_cmd) else $error("writer command filter wrong");

    property p_wr_rd;
        rdValid && securityArmed && serialWriteMode |=> rdOutValid && rdOut == 32'hFFFF_FFFF;
    endproperty
    a_wr_rd: assert property (p_wr_rd) else $error("writer read not blanked");
endmodule // fsg_gate_properties

bind fsg_gate fsg_gate_properties u_fsg_gate_properties (
    .ref_clk(ref_clk), .nrst(nrst), .secRdReq(secRdReq), .secRdAddr(secRdAddr),
    .secRdAck(secRdAck), .secRdData(secRdData), .cmdValid(cmdValid),
    .cmdIsErase(cmdIsErase), .rdValid(rdValid), .rdData(rdData), .dbgValid(dbgValid),
    .cmdGo(cmdGo), .cmdRefused(cmdRefused), .rdOut(rdOut), .rdOutValid(rdOutValid),
    .dbgGrant(dbgGrant), .dbgBlocked(dbgBlocked), .bootDone(bootDone),
    .securityArmed(securityArmed), .serialWriteMode(serialWriteMode),
    .usbTransport(usbTransport));

// ---- src/fsg_access_filter.sv ----
`timescale 1ns/1ns
`include "fsg_params.svh"
module fsg_access_filter
    import fsg_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    fsg_ctl_if.filter        ctl,
    input  wire logic        cmdValid,
    input  wire logic        cmdIsErase,
    input  wire logic        rdValid,
    input  wire logic [31:0] rdData,
    input  wire logic        dbgValid,
    output logic             cmdGo,
    output logic             cmdRefused,
    output logic [31:0]      rdOut,
    output logic             rdOutValid,
    output logic             dbgGrant,
    output logic             dbgBlocked
);
    fsg_filter_type fltReg;
    fsg_filter_type fltNext;
    logic           locked;

    always_comb begin
        fltNext            = fltReg;
        locked             = ctl.armed && ctl.writerMode;
        // Commands once ready: erase always, others unless locked
        // user mode open
        fltNext.cmdGo      = ctl.ready && cmdValid && (cmdIsErase || !locked);
        fltNext.cmdRefused = cmdValid && !(ctl.ready && (cmdIsErase || !locked));
        // Reads
        fltNext.rdOutValid = ctl.ready && rdValid;
        fltNext.rdOut      = locked ? `FSG_INVALID_DATA : rdData;
        if (!rdValid) begin
            fltNext.rdOut = fltReg.rdOut;
        end
        fltNext.dbgGrant   = ctl.ready && dbgValid && !ctl.armed;
        fltNext.dbgBlocked = dbgValid && !(ctl.ready && !ctl.armed);
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            fltReg <= '0;
        end else begin
            fltReg <= fltNext;
        end
    end

    assign cmdGo      = fltReg.cmdGo;
    assign cmdRefused = fltReg.cmdRefused;
    assign rdOut      = fltReg.rdOut;
    assign rdOutValid = fltReg.rdOutValid;
    assign dbgGrant   = fltReg.dbgGrant;
    assign dbgBlocked = fltReg.dbgBlocked;
endmodule // fsg_access_filter

// ---- src/fsg_ctl_if.sv ----
`timescale 1ns/1ns
interface fsg_ctl_if;
    logic mdLow;
    logic mdHigh;
    logic transport;
    logic framing;
    logic oscSel;
    logic extBoot;
    logic dpIn;
    logic dmIn;
    logic armed;
    logic writerMode;
    logic ready;

    modport sync (output mdLow, output mdHigh, output transport, output framing,
                  output oscSel, output extBoot, output dpIn, output dmIn);
    modport gate (input mdLow, input mdHigh, input transport, input framing,
                  input oscSel, input extBoot, input dpIn, input dmIn,
                  output armed, output writerMode, output ready);
    modport filter (input armed, input writerMode, input ready);
endinterface

// ---- src/fsg_gate.sv ----
// Behaviour
// - Protection code arms security only from the next reset onward.
// - Security halfword read at fixed address; only value 0x0001 arms.
// - After chip erase, next reset reads code as unarmed.
// - User mode armed: all commands accepted, reads return valid data.
// - Armed: every debug-port flash access blocked in all modes.
// - Writer mode armed: erase only, others refused, reads invalid.
// - Serial write mode on external reset or power-up with straps 01.
// - Transport strap at reset: high selects USB, low UART.
// - Framing pin high until comm start: async; low: sync.
// - UART: framing pin becomes receive, osc pin becomes transmit.
// - USB: osc pin low means 4MHz, high means 48MHz.
// - USB: pull-up control low connects, high disconnects.
// - USB: dedicated pins become positive and negative data lines.
// - Async bit rate paired with oscillator frequency table.
`timescale 1ns/1ns
`include "fsg_params.svh"
module fsg_gate
    import fsg_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    input  wire logic        bootStrapLowBit,
    input  wire logic        bootStrapHighBit,
    input  wire logic        extResetOrPowerUp,
    input  wire logic        transportSelectPin,
    input  wire logic        framingSelectRxdPin,
    input  wire logic        oscSelectTxdPinIn,
    output logic             oscSelectTxdPinOut,
    output logic             oscSelectTxdPinOe,
    input  wire logic [5:0]  boardOscMhz,
    input  wire logic        commStart,
    input  wire logic        serialTransmitLine,
    output logic             serialReceiveLine,
    input  wire logic        usbPullupReq,
    output logic             usbPullupEnableN,
    input  wire logic        usbPositiveLineIn,
    output logic             usbPositiveLineOut,
    output logic             usbPositiveLineOe,
    input  wire logic        usbNegativeLineIn,
    output logic             usbNegativeLineOut,
    output logic             usbNegativeLineOe,
    input  wire logic        usbDpTx,
    input  wire logic        usbDmTx,
    input  wire logic        usbTxEn,
    output logic             usbDpRx,
    output logic             usbDmRx,
    output logic             secRdReq,
    output logic [31:0]      secRdAddr,
    input  wire logic        secRdAck,
    input  wire logic [15:0] secRdData,
    input  wire logic        cmdValid,
    input  wire logic        cmdIsErase,
    input  wire logic        rdValid,
    input  wire logic [31:0] rdData,
    input  wire logic        dbgValid,
    output logic             cmdGo,
    output logic             cmdRefused,
    output logic [31:0]      rdOut,
    output logic             rdOutValid,
    output logic             dbgGrant,
    output logic             dbgBlocked,
    output logic             bootDone,
    output logic             securityArmed,
    output logic             serialWriteMode,
    output logic             usbTransport,
    output logic             asyncFraming,
    output logic             commActive,
    output logic [5:0]       oscFreqMhz,
    output logic [16:0]      bitRateBps
);
    fsg_ctl_if    ctl ();
    fsg_gate_type gateReg;
    fsg_gate_type gateNext;
    logic [5:0]   effOsc;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    fsg_strap_sync u_sync (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .pinsRaw ({usbNegativeLineIn, usbPositiveLineIn, extResetOrPowerUp,
                   oscSelectTxdPinIn, framingSelectRxdPin, transportSelectPin,
                   bootStrapHighBit, bootStrapLowBit}),
        .ctl     (ctl)
    );

    // ----------------------------------------------------------------
    // Flash access gating
    // ----------------------------------------------------------------
    fsg_access_filter u_filter (
        .ref_clk    (ref_clk),
        .nrst       (nrst),
        .ctl        (ctl),
        .cmdValid   (cmdValid),
        .cmdIsErase (cmdIsErase),
        .rdValid    (rdValid),
        .rdData     (rdData),
        .dbgValid   (dbgValid),
        .cmdGo      (cmdGo),
        .cmdRefused (cmdRefused),
        .rdOut      (rdOut),
        .rdOutValid (rdOutValid),
        .dbgGrant   (dbgGrant),
        .dbgBlocked (dbgBlocked)
    );

    assign ctl.armed      = gateReg.armed;
    assign ctl.writerMode = gateReg.writerMode;
    assign ctl.ready      = gateReg.ready;

    // ----------------------------------------------------------------
    // Oscillator frequency in effect
    // ----------------------------------------------------------------
    always_comb begin
        effOsc = boardOscMhz;
        if (gateReg.writerMode && gateReg.usbMode) begin
            effOsc = gateReg.oscHigh ? `FSG_OSC_48M : `FSG_OSC_4M;
        end
    end

    // ----------------------------------------------------------------
    // Boot sequence and pin muxing
    // ----------------------------------------------------------------
    always_comb begin
        gateNext          = gateReg;
        gateNext.secRdReq = 1'b0;
        case (gateReg.state)
            FSG_SYNC: begin
                // Let the synchronisers fill before sampling
                if (gateReg.waitCnt == `FSG_SYNC_WAIT) begin
                    gateNext.writerMode = ctl.mdLow && !ctl.mdHigh && ctl.extBoot;
                    gateNext.usbMode    = ctl.transport;
                    gateNext.oscHigh    = ctl.oscSel;
                    gateNext.asyncMode  = ctl.framing;
                    gateNext.secRdReq   = 1'b1;
                    gateNext.secRdAddr  = `FSG_SEC_ADDR;
                    gateNext.state      = FSG_READ;
                end else begin
                    gateNext.waitCnt = gateReg.waitCnt + 2'h1;
                end
            end
            FSG_READ: begin
                gateNext.state = FSG_WAIT;
                if (secRdAck) begin
                    gateNext.armed = (secRdData == `FSG_SEC_PROTECT);
                    gateNext.ready = 1'b1;
                    gateNext.state = FSG_RUN;
                end
            end
            FSG_WAIT: begin
                if (secRdAck) begin
                    gateNext.armed = (secRdData == `FSG_SEC_PROTECT);
                    gateNext.ready = 1'b1;
                    gateNext.state = FSG_RUN;
                end
            end
            FSG_RUN: begin
                gateNext.state = FSG_RUN;
            end
            default: begin
                gateNext.state = FSG_SYNC;
            end
        endcase

        if (gateReg.ready && !gateReg.commActive) begin
            gateNext.asyncMode = ctl.framing;
            if (commStart) begin
                gateNext.commActive = 1'b1;
            end
        end

        gateNext.serialRx = gateReg.writerMode && !gateReg.usbMode
                            && gateReg.commActive && ctl.framing;
        gateNext.txdOe    = gateReg.writerMode && !gateReg.usbMode
                            && gateReg.commActive;
        gateNext.txdOut   = gateNext.txdOe && serialTransmitLine;

        gateNext.pullupN = !(gateReg.writerMode && gateReg.usbMode && usbPullupReq);

        gateNext.dpOe  = gateReg.writerMode && gateReg.usbMode && usbTxEn;
        gateNext.dmOe  = gateReg.writerMode && gateReg.usbMode && usbTxEn;
        gateNext.dpOut = gateNext.dpOe && usbDpTx;
        gateNext.dmOut = gateNext.dmOe && usbDmTx;
        gateNext.dpIn  = gateReg.writerMode && gateReg.usbMode && ctl.dpIn;
        gateNext.dmIn  = gateReg.writerMode && gateReg.usbMode && ctl.dmIn;

        gateNext.oscMhz = effOsc;
        case (effOsc)
            `FSG_OSC_4M:  gateNext.bitRate = `FSG_BPS_9600;
            `FSG_OSC_8M:  gateNext.bitRate = `FSG_BPS_19200;
            `FSG_OSC_16M: gateNext.bitRate = `FSG_BPS_38400;
            `FSG_OSC_24M: gateNext.bitRate = `FSG_BPS_57600;
            `FSG_OSC_48M: gateNext.bitRate = `FSG_BPS_115200;
            default:      gateNext.bitRate = `FSG_BPS_NONE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            gateReg         <= '0;
            gateReg.state   <= FSG_SYNC;
            gateReg.pullupN <= 1'b1;
        end else begin
            gateReg <= gateNext;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign oscSelectTxdPinOut = gateReg.txdOut;
    assign oscSelectTxdPinOe  = gateReg.txdOe;
    assign serialReceiveLine  = gateReg.serialRx;
    assign usbPullupEnableN   = gateReg.pullupN;
    assign usbPositiveLineOut = gateReg.dpOut;
    assign usbPositiveLineOe  = gateReg.dpOe;
    assign usbNegativeLineOut = gateReg.dmOut;
    assign usbNegativeLineOe  = gateReg.dmOe;
    assign usbDpRx            = gateReg.dpIn;
    assign usbDmRx            = gateReg.dmIn;
    assign secRdReq           = gateReg.secRdReq;
    assign secRdAddr          = gateReg.secRdAddr;
    assign bootDone           = gateReg.ready;
    assign securityArmed      = gateReg.armed;
    assign serialWriteMode    = gateReg.writerMode;
    assign usbTransport       = gateReg.usbMode;
    assign asyncFraming       = gateReg.asyncMode;
    assign commActive         = gateReg.commActive;
    assign oscFreqMhz         = gateReg.oscMhz;
    assign bitRateBps         = gateReg.bitRate;
endmodule // fsg_gate

// ---- src/fsg_params.svh ----
`ifndef FSG_PARAMS_SVH
`define FSG_PARAMS_SVH

// ----------------------------------------------------------------
// Security code
// ----------------------------------------------------------------
`define FSG_SEC_ADDR        32'h0010_0000
`define FSG_SEC_PROTECT     16'h0001
`define FSG_INVALID_DATA    32'hFFFF_FFFF

// ----------------------------------------------------------------
// Boot sequencing
// ----------------------------------------------------------------
`define FSG_SYNC_WAIT       2'h3
`define FSG_STRAP_WIDTH     6

// ----------------------------------------------------------------
// Oscillator and bit rates
// ----------------------------------------------------------------
`define FSG_OSC_4M          6'h04
`define FSG_OSC_8M          6'h08
`define FSG_OSC_16M         6'h10
`define FSG_OSC_24M         6'h18
`define FSG_OSC_48M         6'h30
`define FSG_BPS_9600        17'h02580
`define FSG_BPS_19200       17'h04B00
`define FSG_BPS_38400       17'h09600
`define FSG_BPS_57600       17'h0E100
`define FSG_BPS_115200      17'h1C200
`define FSG_BPS_NONE        17'h00000

`endif

// ---- src/fsg_pkg.sv ----
package fsg_pkg;

    typedef enum logic [1:0] {
        FSG_SYNC,
        FSG_READ,
        FSG_WAIT,
        FSG_RUN
    } fsg_state_type;

    typedef struct packed {
        logic [7:0] stage1;
        logic [7:0] stage2;
    } fsg_sync_type;

    typedef struct packed {
        logic        cmdGo;
        logic        cmdRefused;
        logic [31:0] rdOut;
        logic        rdOutValid;
        logic        dbgGrant;
        logic        dbgBlocked;
    } fsg_filter_type;

    typedef struct packed {
        fsg_state_type state;
        logic [1:0]    waitCnt;
        logic          armed;
        logic          writerMode;
        logic          usbMode;
        logic          asyncMode;
        logic          oscHigh;
        logic          commActive;
        logic          ready;
        logic          secRdReq;
        logic [31:0]   secRdAddr;
        logic          serialRx;
        logic          txdOut;
        logic          txdOe;
        logic          pullupN;
        logic          dpOut;
        logic          dpOe;
        logic          dmOut;
        logic          dmOe;
        logic          dpIn;
        logic          dmIn;
        logic [5:0]    oscMhz;
        logic [16:0]   bitRate;
    } fsg_gate_type;

endpackage

// ---- src/fsg_strap_sync.sv ----
`timescale 1ns/1ns
`include "fsg_params.svh"
module fsg_strap_sync
    import fsg_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic nrst,
    input  wire logic [`FSG_STRAP_WIDTH+1:0] pinsRaw,
    fsg_ctl_if.sync   ctl
);
    fsg_sync_type syncReg;
    fsg_sync_type syncNext;

    // ----------------------------------------------------------------
    // Two-flop synchronisers, one per pin
    // ----------------------------------------------------------------
    always_comb begin
        syncNext        = syncReg;
        syncNext.stage1 = pinsRaw;
        syncNext.stage2 = syncReg.stage1;
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            syncReg <= '0;
        end else begin
            syncReg <= syncNext;
        end
    end

    assign ctl.mdLow     = syncReg.stage2[0];
    assign ctl.mdHigh    = syncReg.stage2[1];
    assign ctl.transport = syncReg.stage2[2];
    assign ctl.framing   = syncReg.stage2[3];
    assign ctl.oscSel    = syncReg.stage2[4];
    assign ctl.extBoot   = syncReg.stage2[5];
    assign ctl.dpIn      = syncReg.stage2[6];
    assign ctl.dmIn      = syncReg.stage2[7];
endmodule // fsg_strap_sync
